// file: inc/psufs_pkg.sv
// psufs_pkg: constants for the power supply fault supervisor
// assumes a single 20 MHz clock; all fault levels arrive as comparator outputs
package psufs_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int STBY_BAND_MS = 10;
    localparam int STBY_OC_HICCUP_MS = 10;
    localparam int OCP_LATCH_MS = 75;
    localparam int OCW_ALERT_MS = 30;
    localparam int ALERT_HOLD_MS = 100;
    localparam int TURN_ON_BLANK_MS = 2;
    localparam int DC_OFF_S = 15;
    localparam int PSON_HIGH_S = 1;
    localparam int STBY_BAND_CYC = CLK_HZ / 1000 * STBY_BAND_MS;
    localparam int STBY_OC_CYC = CLK_HZ / 1000 * STBY_OC_HICCUP_MS;
    localparam int OCP_LATCH_CYC = CLK_HZ / 1000 * OCP_LATCH_MS;
    localparam int OCW_ALERT_CYC = CLK_HZ / 1000 * OCW_ALERT_MS;
    localparam int ALERT_HOLD_CYC = CLK_HZ / 1000 * ALERT_HOLD_MS;
    localparam int TURN_ON_BLANK_CYC = CLK_HZ / 1000 * TURN_ON_BLANK_MS;
    localparam int DC_OFF_CYC = CLK_HZ * DC_OFF_S;
    localparam int PSON_HIGH_CYC = CLK_HZ * PSON_HIGH_S;
    localparam int CNT_W = 32;
    // ************************************************************
    // reset values and states
    // ************************************************************
    localparam logic RST_LATCH = 1'b0;
    typedef enum logic [3:0] {
        PSUFS_OFF = 4'h1,
        PSUFS_BLANK = 4'h2,
        PSUFS_ON = 4'h4,
        PSUFS_LATCHED = 4'h8
    } psufs_state_type;
endpackage

// file: hdl/psufs_qual.sv
// psufs_qual: synchronises one comparator and qualifies its duration
// assumes an asynchronous input; flag_o rises once the level held limit_i cycles
`timescale 1ns/100ps
`default_nettype none
module psufs_qual
    import psufs_pkg::*;
(
    input wire logic clk_i,                 // system clock
    input wire logic rst_i,                 // synchronous reset
    input wire logic raw_i,                 // asynchronous comparator
    input wire logic [CNT_W-1:0] limit_i,   // qualifying count
    output logic level_o,                   // synchronised level
    output logic flag_o                     // held long enough
);
    logic meta_reg;
    logic sync_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic at_limit;

    // RULE22 sync and count
    assign at_limit = (cnt_reg >= limit_i);
    assign cnt_next = !sync_reg ? '0 : (at_limit ? cnt_reg : cnt_reg + 1'b1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            cnt_reg <= '0;
            flag_o <= 1'b0;
        end else begin
            meta_reg <= raw_i;
            sync_reg <= meta_reg;
            cnt_reg <= cnt_next;
            flag_o <= sync_reg && (cnt_next >= limit_i);
        end
    end
    assign level_o = sync_reg;
endmodule
`default_nettype wire

// file: hdl/psufs_top.sv
// psufs_top: fault supervision and protection sequencing of the supply
// assumes comparator and pin inputs are asynchronous; outputs drive pin buffers
//
// Summary of operation
// RULE1 - protection trips remove only the main rail
// RULE2 - latch clears after 15 s input removal plus 1 s request high
// RULE3 - over-temperature removes main rail until cool
// RULE4 - trip comparator sits 5 C above warning for hysteresis
// RULE5 - main over-voltage latches off; input loss or request toggle clears
// RULE6 - standby over-voltage never latches; standby recovers when it clears
// RULE7 - power good drops whenever any rail leaves its 5 percent band
// RULE8 - main under 11.2 V latches off; input loss or request toggle clears
// RULE9 - standby out of band beyond 10 ms disables the main rail
// RULE10 - main over-current latch clears only on input power interruption
// RULE11 - standby over-current hiccups standby after at least 10 ms
// RULE12 - over-power folds main back to 8 V within 100 us, no latch
// RULE13 - slow over-current persisting 50 to 100 ms latches main off
// RULE14 - slow over-current warning asserts alert after 15 to 50 ms
// RULE15 - alert asserts on approaching over-power, before the fold threshold
// RULE16 - alert once asserted is held about 100 ms before release
// RULE17 - share pin is disconnected on internal fault or when not turned on
// RULE18 - largest-current unit is master; slaves trim up at most 250 mV
// RULE19 - no-load operation never trips any fault logic
// RULE20 - residual output voltage up to 500 mV causes no trip at turn-on
// RULE21 - active-low request enables main rail only when no latch is set
// RULE22 - comparators synchronised; durations counted in clock cycles
`timescale 1ns/100ps
`default_nettype none
module psufs_top
    import psufs_pkg::*;
#(
    parameter int DC_OFF_CYCLES = DC_OFF_CYC,
    parameter int PSON_HIGH_CYCLES = PSON_HIGH_CYC,
    parameter int OCP_CYCLES = OCP_LATCH_CYC,
    parameter int OCW_CYCLES = OCW_ALERT_CYC,
    parameter int ALERT_HOLD_CYCLES = ALERT_HOLD_CYC,
    parameter int STBY_BAND_CYCLES = STBY_BAND_CYC,
    parameter int STBY_OC_CYCLES = STBY_OC_CYC,
    parameter int BLANK_CYCLES = TURN_ON_BLANK_CYC
) (
    input wire logic clk_i,                      // 20 MHz clock
    input wire logic rst_i,                      // synchronous reset
    input wire logic turn_on_request_n_i,        // host request, active low
    input wire logic dc_input_ok_i,              // dc input present
    input wire logic main_ov_i,                  // main over-voltage comparator
    input wire logic main_uv_i,                  // main below 11.2 V
    input wire logic main_out_band_i,            // main outside 5 percent
    input wire logic stby_ov_i,                  // standby over-voltage
    input wire logic stby_out_band_i,            // standby outside 5 percent
    input wire logic stby_oc_i,                  // standby over-current
    input wire logic main_oc_fast_i,             // over-power threshold reached
    input wire logic main_op_warn_i,             // approaching over-power
    input wire logic main_oc_slow_i,             // slow over-current level
    input wire logic over_temp_i,                // trip comparator, above warning
    input wire logic share_highest_i,            // own current above share bus
    output logic main_enable_o,                  // main rail enable
    output logic over_power_fold_o,              // fold main to 8 V
    output logic standby_enable_o,               // standby rail enable
    output logic power_good_out_o,               // power good, high = good
    output logic host_alert_n_o,                 // alert to host, active low
    output logic current_share_pin_connect_o,    // share pin switch closed
    output logic share_master_o,                 // unit is share master
    output logic share_trim_up_o                 // slave trims up (capped 250 mV)
);
    // ************************************************************
    // input synchronisation and qualification
    // ************************************************************
    logic req_s;
    logic dc_s;
    logic m_ov_s;
    logic m_uv_s;
    logic m_band_s;
    logic s_ov_s;
    logic s_band_s;
    logic s_band_long;
    logic s_oc_s;
    logic s_oc_long;
    logic opp_s;
    logic warn_s;
    logic oc_slow_s;
    logic ocp_long;
    logic ocw_long;
    logic ot_s;
    logic share_hi_s;
    logic dc_low_long;
    logic req_high_long;

    psufs_qual u_req (.clk_i(clk_i), .rst_i(rst_i), .raw_i(~turn_on_request_n_i),
        .limit_i(32'h1), .level_o(req_s), .flag_o());
    psufs_qual u_dc (.clk_i(clk_i), .rst_i(rst_i), .raw_i(dc_input_ok_i),
        .limit_i(32'h1), .level_o(dc_s), .flag_o());
    psufs_qual u_mov (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_ov_i),
        .limit_i(32'h1), .level_o(m_ov_s), .flag_o());
    psufs_qual u_muv (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_uv_i),
        .limit_i(32'h1), .level_o(m_uv_s), .flag_o());
    psufs_qual u_mband (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_out_band_i),
        .limit_i(32'h1), .level_o(m_band_s), .flag_o());
    psufs_qual u_sov (.clk_i(clk_i), .rst_i(rst_i), .raw_i(stby_ov_i),
        .limit_i(32'h1), .level_o(s_ov_s), .flag_o());
    // RULE9 standby band timer
    psufs_qual u_sband (.clk_i(clk_i), .rst_i(rst_i), .raw_i(stby_out_band_i),
        .limit_i(CNT_W'(STBY_BAND_CYCLES)), .level_o(s_band_s), .flag_o(s_band_long));
    // RULE11 standby overcurrent delay
    psufs_qual u_soc (.clk_i(clk_i), .rst_i(rst_i), .raw_i(stby_oc_i),
        .limit_i(CNT_W'(STBY_OC_CYCLES)), .level_o(s_oc_s), .flag_o(s_oc_long));
    psufs_qual u_opp (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_oc_fast_i),
        .limit_i(32'h1), .level_o(opp_s), .flag_o());
    psufs_qual u_warn (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_op_warn_i),
        .limit_i(32'h1), .level_o(warn_s), .flag_o());
    // RULE13 slow overcurrent persistence
    psufs_qual u_ocp (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_oc_slow_i),
        .limit_i(CNT_W'(OCP_CYCLES)), .level_o(oc_slow_s), .flag_o(ocp_long));
    // RULE14 warning persistence
    psufs_qual u_ocw (.clk_i(clk_i), .rst_i(rst_i), .raw_i(main_oc_slow_i),
        .limit_i(CNT_W'(OCW_CYCLES)), .level_o(), .flag_o(ocw_long));
    // RULE4 trip comparator already carries the 5 C margin over warning
    psufs_qual u_ot (.clk_i(clk_i), .rst_i(rst_i), .raw_i(over_temp_i),
        .limit_i(32'h1), .level_o(ot_s), .flag_o());
    psufs_qual u_shr (.clk_i(clk_i), .rst_i(rst_i), .raw_i(share_highest_i),
        .limit_i(32'h1), .level_o(share_hi_s), .flag_o());
    // RULE2 long input loss and long request release
    psufs_qual u_dcoff (.clk_i(clk_i), .rst_i(rst_i), .raw_i(~dc_input_ok_i),
        .limit_i(CNT_W'(DC_OFF_CYCLES)), .level_o(), .flag_o(dc_low_long));
    psufs_qual u_reqhi (.clk_i(clk_i), .rst_i(rst_i), .raw_i(turn_on_request_n_i),
        .limit_i(CNT_W'(PSON_HIGH_CYCLES)), .level_o(), .flag_o(req_high_long));

    // ************************************************************
    // latches and main rail sequencing
    // ************************************************************
    psufs_state_type state_reg;
    psufs_state_type state_next;
    logic ov_latch_reg;
    logic uv_latch_reg;
    logic oc_latch_reg;
    logic dc_seen_off_reg;
    logic [CNT_W-1:0] blank_reg;
    logic any_latch;
    logic trips_armed;
    logic req_toggle_clear;
    logic dc_clear;
    logic latch_clear_2;

    // RULE20 turn-on blanking masks residual under-voltage
    // RULE19 trips come only from comparators; light load raises none of them
    assign trips_armed = (state_reg == PSUFS_ON);
    assign any_latch = ov_latch_reg | uv_latch_reg | oc_latch_reg;
    // RULE5 request toggle clears voltage latches
    assign req_toggle_clear = !req_s;
    // RULE10 dc loss clears every latch, including overcurrent
    assign dc_clear = !dc_s;
    // RULE2 the combined recovery sequence also clears
    assign latch_clear_2 = dc_seen_off_reg && req_high_long;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dc_seen_off_reg <= RST_LATCH;
        end else if (latch_clear_2) begin
            dc_seen_off_reg <= 1'b0;
        end else if (dc_low_long) begin
            dc_seen_off_reg <= 1'b1;
        end
    end

    // set wins over clear on every latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov_latch_reg <= RST_LATCH;
            uv_latch_reg <= RST_LATCH;
            oc_latch_reg <= RST_LATCH;
        end else begin
            // RULE5 main over-voltage latch, armed whenever main enabled
            if (m_ov_s && main_enable_o) begin
                ov_latch_reg <= 1'b1;
            end else if (req_toggle_clear || dc_clear || latch_clear_2) begin
                ov_latch_reg <= 1'b0;
            end
            // RULE8 main under-voltage latch
            if (m_uv_s && trips_armed) begin
                uv_latch_reg <= 1'b1;
            end else if (req_toggle_clear || dc_clear || latch_clear_2) begin
                uv_latch_reg <= 1'b0;
            end
            // RULE13 slow overcurrent latch
            if (ocp_long && main_enable_o) begin
                oc_latch_reg <= 1'b1;
            end else if (dc_clear || latch_clear_2) begin
                oc_latch_reg <= 1'b0;
            end
        end
    end

    // RULE21 enable only with request and no latch
    // RULE3 over-temperature and RULE9 standby fault hold main off, not latched
    logic run_ok;
    assign run_ok = req_s && dc_s && !any_latch && !ot_s && !s_band_long;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSUFS_OFF: begin
                if (run_ok) begin
                    state_next = PSUFS_BLANK;
                end
            end
            PSUFS_BLANK: begin
                if (!run_ok) begin
                    state_next = any_latch ? PSUFS_LATCHED : PSUFS_OFF;
                end else if (blank_reg >= CNT_W'(BLANK_CYCLES)) begin
                    state_next = PSUFS_ON;
                end
            end
            PSUFS_ON: begin
                if (!run_ok) begin
                    state_next = any_latch ? PSUFS_LATCHED : PSUFS_OFF;
                end
            end
            PSUFS_LATCHED: begin
                if (!any_latch) begin
                    state_next = PSUFS_OFF;
                end
            end
            default: begin
                state_next = PSUFS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= PSUFS_OFF;
            blank_reg <= '0;
        end else begin
            state_reg <= state_next;
            blank_reg <= (state_reg == PSUFS_BLANK) ? blank_reg + 1'b1 : '0;
        end
    end

    // ************************************************************
    // alert
    // ************************************************************
    logic [CNT_W-1:0] alert_cnt_reg;
    logic alert_cause;
    // RULE15 approaching over-power raises alert ahead of the fold
    assign alert_cause = warn_s || opp_s || ocw_long;

    // RULE16 hold alert for the full hold time after last cause
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_cnt_reg <= '0;
        end else if (alert_cause) begin
            alert_cnt_reg <= CNT_W'(ALERT_HOLD_CYCLES);
        end else if (alert_cnt_reg != '0) begin
            alert_cnt_reg <= alert_cnt_reg - 1'b1;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic main_on;
    logic stby_on;
    assign main_on = (state_next == PSUFS_BLANK) || (state_next == PSUFS_ON);
    // RULE1 standby depends only on its own faults
    // RULE6 standby over-voltage holds off only while present
    // RULE11 hiccup: off while the qualified overload persists
    assign stby_on = dc_s && !s_ov_s && !s_oc_long;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_enable_o <= 1'b0;
            over_power_fold_o <= 1'b0;
            standby_enable_o <= 1'b0;
            power_good_out_o <= 1'b0;
            host_alert_n_o <= 1'b1;
            current_share_pin_connect_o <= 1'b0;
            share_master_o <= 1'b0;
            share_trim_up_o <= 1'b0;
        end else begin
            main_enable_o <= main_on;
            // RULE12 fold, no latch, well under 100 us
            over_power_fold_o <= opp_s && main_on;
            standby_enable_o <= stby_on;
            // RULE7 power good needs both rails in band
            power_good_out_o <= (state_reg == PSUFS_ON) && !m_band_s && !s_band_s && stby_on;
            // RULE14 warning and RULE16 hold drive the alert
            host_alert_n_o <= !(alert_cause || (alert_cnt_reg != '0));
            // RULE17 share pin only when on and healthy
            current_share_pin_connect_o <= (state_reg == PSUFS_ON) && !any_latch;
            // RULE18 largest current is master; trim cap is analog
            share_master_o <= (state_reg == PSUFS_ON) && !any_latch && share_hi_s;
            share_trim_up_o <= (state_reg == PSUFS_ON) && !any_latch && !share_hi_s;
        end
    end
endmodule
`default_nettype wire

// file: dv/psufs_top_asserts.sv
// psufs_top_asserts: port-level checks
// assumes it is bound into psufs_top; the alert hold count comes from the bind
`timescale 1ns/100ps
`default_nettype none
module psufs_top_asserts
    import psufs_pkg::*;
#(
    parameter int ALERT_HOLD_CYCLES = ALERT_HOLD_CYC
) (
    input wire logic clk_i,                       // clock
    input wire logic rst_i,                       // reset
    input wire logic turn_on_request_n_i,         // host request
    input wire logic dc_input_ok_i,               // dc present
    input wire logic main_ov_i,                   // main over-voltage
    input wire logic stby_ov_i,                   // standby over-voltage
    input wire logic stby_oc_i,                   // standby over-current
    input wire logic main_out_band_i,             // main out of band
    input wire logic main_oc_fast_i,              // over-power level
    input wire logic over_temp_i,                 // over-temperature
    input wire logic main_enable_o,               // main on
    input wire logic over_power_fold_o,           // fold back
    input wire logic standby_enable_o,            // standby on
    input wire logic power_good_out_o,            // power good
    input wire logic host_alert_n_o,              // alert
    input wire logic current_share_pin_connect_o, // share pin
    input wire logic share_master_o,              // master role
    input wire logic share_trim_up_o              // slave trim
);
    // ************************************************************
    // helper counters
    // ************************************************************
    logic [3:0] sb_quiet_reg;
    logic [3:0] req_off_reg;
    logic [3:0] req_on_reg;
    logic [CNT_W-1:0] alert_low_reg;
    // 4-bit counters saturate so a long idle run cannot wrap into a false pass; alert_low_reg counts without saturating
    wire logic sb_cause = stby_ov_i | stby_oc_i | ~dc_input_ok_i;
    always_ff @(posedge clk_i) begin
        sb_quiet_reg <= (rst_i | sb_cause) ? 4'h0 : sb_quiet_reg + 4'(sb_quiet_reg != 4'hF);
        req_off_reg <= (rst_i | ~turn_on_request_n_i) ? 4'h0 : req_off_reg + 4'(req_off_reg != 4'hF);
        req_on_reg <= (rst_i | turn_on_request_n_i) ? 4'h0 : req_on_reg + 4'(req_on_reg != 4'hF);
        alert_low_reg <= (rst_i | host_alert_n_o) ? 32'h0 : alert_low_reg + 32'h1;
    end
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_stby_kept; $fell(standby_enable_o) |-> sb_quiet_reg < 4'h6; endproperty
    a_stby_kept: assert property (p_stby_kept) else $error("standby dropped");
    property p_ov_off; main_ov_i [*3] |-> ##[0:3] !main_enable_o; endproperty
    a_ov_off: assert property (p_ov_off) else $error("main on in ov");
    property p_req_hold; main_enable_o |-> req_off_reg < 4'h8; endproperty
    a_req_hold: assert property (p_req_hold) else $error("main on unasked");
    property p_rise_req; $rose(main_enable_o) |-> req_on_reg > 4'h2; endproperty
    a_rise_req: assert property (p_rise_req) else $error("main rose unasked");
    property p_pg_band; main_out_band_i [*4] |-> ##[0:2] !power_good_out_o; endproperty
    a_pg_band: assert property (p_pg_band) else $error("pg out of band");
    property p_alert_hold; $rose(host_alert_n_o) |-> alert_low_reg >= ALERT_HOLD_CYCLES; endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert released early");
    property p_alert_first; $rose(over_power_fold_o) |-> !host_alert_n_o; endproperty
    a_alert_first: assert property (p_alert_first) else $error("fold before alert");
    property p_fold_fast; (main_oc_fast_i && main_enable_o) [*4] |-> ##[0:2] over_power_fold_o; endproperty
    a_fold_fast: assert property (p_fold_fast) else $error("fold too slow");
    property p_share_off; turn_on_request_n_i [*8] |-> !current_share_pin_connect_o && !main_enable_o; endproperty
    a_share_off: assert property (p_share_off) else $error("share pin kept while off");
    property p_trim; share_trim_up_o |-> !share_master_o && current_share_pin_connect_o; endproperty
    a_trim: assert property (p_trim) else $error("bad trim");
    property p_ot_off; over_temp_i [*4] |-> ##[0:2] !main_enable_o; endproperty
    a_ot_off: assert property (p_ot_off) else $error("main on hot");
endmodule
bind psufs_top psufs_top_asserts #(.ALERT_HOLD_CYCLES(ALERT_HOLD_CYCLES)) psufs_top_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .turn_on_request_n_i(turn_on_request_n_i), .dc_input_ok_i(dc_input_ok_i),
    .main_ov_i(main_ov_i), .stby_ov_i(stby_ov_i), .stby_oc_i(stby_oc_i), .main_out_band_i(main_out_band_i),
    .main_oc_fast_i(main_oc_fast_i), .over_temp_i(over_temp_i), .main_enable_o(main_enable_o),
    .over_power_fold_o(over_power_fold_o), .standby_enable_o(standby_enable_o), .power_good_out_o(power_good_out_o),
    .host_alert_n_o(host_alert_n_o), .current_share_pin_connect_o(current_share_pin_connect_o),
    .share_master_o(share_master_o), .share_trim_up_o(share_trim_up_o));
`default_nettype wire

// file: dv/psufs_host_model.sv
// psufs_host_model: system host and paralleled supplies as seen at the pins
// assumes the bench changes its wishes at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module psufs_host_model (
    input wire logic want_on_i,        // host wants the main rail
    input wire logic carry_most_i,     // this unit carries the largest current
    output logic turn_on_request_n_o,  // request pin, active low
    output logic share_highest_o       // share bus comparison
);
    assign turn_on_request_n_o = ~want_on_i;
    // share verdict is steady: no glitch modelled
    assign share_highest_o = carry_most_i;
endmodule
`default_nettype wire

// file: dv/tb_psu_fault_supervisor.sv
// tb_psu_fault_supervisor: directed scenarios
// assumes the checker binds itself; host pins come from the host model
`timescale 1ns/100ps
`default_nettype none
module tb_psu_fault_supervisor;
    import psufs_pkg::*;
    logic clk = 1'b0;
    logic rst_i = 1'b1;
    logic want_on = 1'b0;
    logic most = 1'b1;
    logic dc = 1'b1, m_ov = 1'b0, m_uv = 1'b0, m_band = 1'b0, s_ov = 1'b0, s_band = 1'b0;
    logic s_oc = 1'b0, fast = 1'b0, warn = 1'b0, slow = 1'b0, ot = 1'b0;
    wire logic req_n, highest, main_en, fold, sb_en, pg, alert_n, share_con, master, trim;
    int err_total = 0;
    int n_checks = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    psufs_host_model psufs_host_model_i (.want_on_i(want_on), .carry_most_i(most),
        .turn_on_request_n_o(req_n), .share_highest_o(highest));
    psufs_top #(.OCP_CYCLES(50), .OCW_CYCLES(20),
        .ALERT_HOLD_CYCLES(40), .STBY_BAND_CYCLES(10), .STBY_OC_CYCLES(10), .BLANK_CYCLES(5)) psufs_top_i (
        .clk_i(clk), .rst_i(rst_i), .turn_on_request_n_i(req_n), .dc_input_ok_i(dc), .main_ov_i(m_ov),
        .main_uv_i(m_uv), .main_out_band_i(m_band), .stby_ov_i(s_ov), .stby_out_band_i(s_band), .stby_oc_i(s_oc),
        .main_oc_fast_i(fast), .main_op_warn_i(warn), .main_oc_slow_i(slow), .over_temp_i(ot),
        .share_highest_i(highest), .main_enable_o(main_en), .over_power_fold_o(fold), .standby_enable_o(sb_en),
        .power_good_out_o(pg), .host_alert_n_o(alert_n), .current_share_pin_connect_o(share_con),
        .share_master_o(master), .share_trim_up_o(trim));
    // ************************************************************
    // helpers and scenarios
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic seen, input logic exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic toggle();
        want_on = 1'b0;
        cyc(10);
        want_on = 1'b1;
        cyc(24);
    endtask
    task automatic t_power_on();
        m_uv = 1'b1;
        cyc(8);
        chk(sb_en, 1'b1, "standby up");
        chk(main_en, 1'b0, "main off");
        want_on = 1'b1;
        cyc(3);
        m_uv = 1'b0;
        cyc(20);
        chk(main_en, 1'b1, "main up");
        chk(pg, 1'b1, "power good");
        chk(share_con, 1'b1, "share pin on");
        chk(master, 1'b1, "master role");
        most = 1'b0;
        cyc(40);
        chk(master, 1'b0, "slave role");
        chk(main_en, 1'b1, "idle up");
        chk(alert_n, 1'b1, "no idle alert");
    endtask
    task automatic t_latches();
        for (int k = 0; k < 2; k++) begin
            // short pulse: latch outlives cause
            m_ov = (k == 0);
            m_uv = (k == 1);
            cyc(3);
            m_ov = 1'b0;
            m_uv = 1'b0;
            cyc(8);
            chk(main_en, 1'b0, "fault drops main");
            chk(sb_en, 1'b1, "standby kept");
            chk(pg, 1'b0, "power good drops");
            chk(share_con, 1'b0, "share pin off");
            cyc(20);
            chk(main_en, 1'b0, "latch holds");
            toggle();
            chk(main_en, 1'b1, "toggle clears");
        end
    endtask
    task automatic t_slow_oc();
        slow = 1'b1;
        cyc(12);
        chk(alert_n, 1'b1, "warning not early");
        cyc(14);
        chk(alert_n, 1'b0, "warning raised");
        chk(main_en, 1'b1, "no early latch");
        cyc(34);
        chk(main_en, 1'b0, "oc latch");
        chk(sb_en, 1'b1, "standby kept");
        slow = 1'b0;
        cyc(20);
        chk(alert_n, 1'b0, "alert held");
        toggle();
        chk(main_en, 1'b0, "toggle ignored");
        chk(alert_n, 1'b1, "alert released");
        dc = 1'b0;
        cyc(25);
        dc = 1'b1;
        cyc(30);
        chk(main_en, 1'b1, "dc loss clears");
    endtask
    task automatic t_over_power();
        warn = 1'b1;
        cyc(6);
        chk(alert_n, 1'b0, "alert on approach");
        chk(fold, 1'b0, "no fold yet");
        fast = 1'b1;
        cyc(6);
        chk(fold, 1'b1, "fold back");
        chk(main_en, 1'b1, "fold not latched");
        fast = 1'b0;
        warn = 1'b0;
        cyc(8);
        chk(fold, 1'b0, "fold released");
        chk(alert_n, 1'b0, "alert held");
        cyc(45);
        chk(alert_n, 1'b1, "alert released");
    endtask
    task automatic t_over_temp();
        ot = 1'b1;
        cyc(8);
        chk(main_en, 1'b0, "hot main off");
        chk(sb_en, 1'b1, "hot standby on");
        ot = 1'b0;
        cyc(20);
        chk(main_en, 1'b1, "cool main back");
    endtask
    task automatic t_bands();
        m_band = 1'b1;
        cyc(6);
        chk(pg, 1'b0, "main band drop");
        m_band = 1'b0;
        cyc(6);
        chk(pg, 1'b1, "good again");
        s_band = 1'b1;
        cyc(6);
        chk(pg, 1'b0, "standby band drop");
        chk(main_en, 1'b1, "short excursion");
        cyc(10);
        chk(main_en, 1'b0, "long excursion");
        s_band = 1'b0;
        cyc(8);
    endtask
    task automatic t_stby_rail();
        s_ov = 1'b1;
        cyc(6);
        chk(sb_en, 1'b0, "standby ov off");
        s_ov = 1'b0;
        cyc(8);
        chk(sb_en, 1'b1, "standby ov recovers");
        s_oc = 1'b1;
        cyc(6);
        chk(sb_en, 1'b1, "hiccup delay");
        cyc(12);
        chk(sb_en, 1'b0, "hiccup off");
        s_oc = 1'b0;
        cyc(8);
        chk(sb_en, 1'b1, "hiccup recovers");
    endtask
    initial begin
        cyc(3);
        chk(main_en, 1'b0, "main off in reset");
        chk(alert_n, 1'b1, "alert in reset");
        cyc(1);
        rst_i = 1'b0;
        t_power_on();
        t_latches();
        t_slow_oc();
        t_over_power();
        t_over_temp();
        t_bands();
        t_stby_rail();
        results();
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
